// ---- logic/ppcs_mode_resolve.sv ----
`timescale 1ns/1ps
// operating speed, duplex and wiring from control and negotiation
module ppcs_mode_resolve (
  input  wire logic an_en_i,
  input  wire logic an_done_i,
  input  wire logic an_speed_i,
  input  wire logic an_duplex_i,
  input  wire logic force_speed_i,
  input  wire logic force_duplex_i,
  input  wire logic amdix_dis_i,
  input  wire logic force_mdix_i,
  input  wire logic auto_mdix_i,
  output logic      speed_o,
  output logic      duplex_o,
  output logic      mdix_o
);

  logic an_ok;

  assign an_ok = an_en_i & an_done_i;

  // forced speed when negotiation is off, negotiated otherwise
  assign speed_o  = an_en_i ? an_speed_i : force_speed_i; // [R7] [R8]
  // forced duplex also covers a failed negotiation
  assign duplex_o = an_ok ? an_duplex_i : force_duplex_i; // [R7] [R9]
  // forced wiring only once automatic selection is off
  assign mdix_o   = amdix_dis_i ? force_mdix_i : auto_mdix_i; // [R5]

endmodule

// ---- logic/ppcs_pkg.sv ----
package ppcs_pkg;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_CTRL       = 12'h512;
  localparam logic [11:0] IDX_STAT       = 12'h514;
  localparam logic [11:0] IDX_RSVD_FIRST = 12'h516;
  localparam logic [11:0] IDX_RSVD_LAST  = 12'h51a;
  localparam int          ADDR_W         = 14;
  localparam int          DATA_W         = 32;
  localparam int          REG_W          = 16;

  // control word field positions
  localparam int CTL_LED_OFF   = 15;
  localparam int CTL_TX_DIS    = 14;
  localparam int CTL_AN_RESTART = 13;
  localparam int CTL_FEF_DIS   = 12;
  localparam int CTL_PWR_DOWN  = 11;
  localparam int CTL_AMDIX_DIS = 10;
  localparam int CTL_FORCE_MDIX = 9;
  localparam int CTL_LOOPBACK  = 8;
  localparam int CTL_AN_EN     = 7;
  localparam int CTL_SPEED     = 6;
  localparam int CTL_DUPLEX    = 5;
  localparam int CTL_ADV_MSB   = 4;

  // status word field positions
  localparam int STS_XVARIANT  = 15;
  localparam int STS_POL_REV   = 13;
  localparam int STS_RX_FC     = 12;
  localparam int STS_TX_FC     = 11;
  localparam int STS_SPEED     = 10;
  localparam int STS_DUPLEX    = 9;
  localparam int STS_FEF       = 8;
  localparam int STS_MDIX      = 7;
  localparam int STS_AN_DONE   = 6;
  localparam int STS_LINK      = 5;
  localparam int STS_LP_MSB    = 4;

  // basic control alias positions
  localparam int ALS_LED_OFF   = 0;
  localparam int ALS_TX_DIS    = 1;
  localparam int ALS_FEF_DIS   = 2;
  localparam int ALS_AMDIX_DIS = 3;
  localparam int ALS_FORCE_MDIX = 4;
  localparam int ALS_XVARIANT  = 5;
  localparam int ALS_DUPLEX    = 8;
  localparam int ALS_AN_RESTART = 9;
  localparam int ALS_PWR_DOWN  = 11;
  localparam int ALS_AN_EN     = 12;
  localparam int ALS_SPEED     = 13;
  localparam int ALS_LOOPBACK  = 14;

  // reset values
  localparam logic [15:0] CTRL_RST     = 16'h009f;
  localparam logic        XVARIANT_RST = 1'b0;
  localparam logic [15:0] RSVD_VALUE   = 16'h0000;

  localparam int N_IND  = 4;
  localparam int N_ABIL = 5;
  localparam int N_STS_IN = 14;

endpackage

// ---- logic/ppcs_regs.sv ----
// Register access over APB was decided locally.
`timescale 1ns/1ps
// Overview of operation
// [R1] control bit 15 drives all four indicator pins high
// [R2] control bit 14 disables the transmitter
// [R3] writing one to control bit 13 restarts auto-negotiation
// [R4] control bit 12 stops far-end fault detection and pattern sending
// [R5] bit 10 disables auto crossover; then bit 9 forces crossed wiring
// [R6] control bit 8 loops port two traffic at port one media layer
// [R7] bit 7, reset one, enables negotiation; else bits 6, 5 decide
// [R8] without negotiation bit 6 forces 100 (one) or 10 (zero)
// [R9] bit 5 picks duplex when negotiation is off or fails
// [R10] bits 4..0, reset one, advertise pause and four speed modes
// [R11] writable status bit 15 selects crossover algorithm variant
// [R12] status bit 13 shows reversed polarity; bit 14 reads zero
// [R13] status bits 12, 11 show receive and transmit flow control
// [R14] status bit 10 shows speed, bit 9 shows duplex
// [R15] status bit 8 is set while far-end fault is detected
// [R16] status bits 4..0 show link partner abilities
// [R17] reserved words after status read zero and ignore writes
// [R18] status bits 7, 6, 5 show crossed wiring, negotiation done, link
// [R19] bit 11 powers down; aliased phy views match the words
module ppcs_regs
  import ppcs_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       resetn_i,
  // apb slave
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [ppcs_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [ppcs_pkg::DATA_W-1:0] pwdata_i,
  input  wire logic [3:0]                 pstrb_i,
  output logic      [ppcs_pkg::DATA_W-1:0] prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  // indicator pins
  input  wire logic [ppcs_pkg::N_IND-1:0] indicator_src_i,
  output logic                            indicator_out_3_o,
  output logic                            indicator_out_2_o,
  output logic                            indicator_out_1_o,
  output logic                            indicator_out_0_o,
  // transceiver status, asynchronous to clk_i
  input  wire logic                       polarity_rev_i,
  input  wire logic                       rx_flow_active_i,
  input  wire logic                       tx_flow_active_i,
  input  wire logic                       far_end_fault_i,
  input  wire logic                       auto_mdix_i,
  input  wire logic                       an_done_i,
  input  wire logic                       link_good_i,
  input  wire logic                       an_speed_i,
  input  wire logic                       an_duplex_i,
  input  wire logic [ppcs_pkg::N_ABIL-1:0] partner_abil_i,
  // transceiver controls
  output logic                            tx_disable_o,
  output logic                            an_restart_o,
  output logic                            fef_enable_o,
  output logic                            power_down_o,
  output logic                            mdix_select_o,
  output logic                            loopback_o,
  output logic                            an_enable_o,
  output logic                            op_speed_o,
  output logic                            op_duplex_o,
  output logic [ppcs_pkg::N_ABIL-1:0]     advert_o,
  output logic                            crossover_variant_select_o,
  // phy-level aliased views
  output logic [ppcs_pkg::REG_W-1:0]      phy_basic_control_alias_o,
  output logic [ppcs_pkg::REG_W-1:0]      phy_advert_alias_o,
  output logic [ppcs_pkg::REG_W-1:0]      phy_basic_status_alias_o
);

  // ------------------------------------------------------------------
  // address decode helpers
  // ------------------------------------------------------------------

  // byte address of a register index, word aligned
  function automatic logic [ADDR_W-1:0] idx_addr(input logic [11:0] idx);
    idx_addr = {idx, 2'b00};
  endfunction

  // low sixteen bits merged under the two low byte lanes
  function automatic logic [REG_W-1:0] lane_merge(
    input logic [REG_W-1:0] old_v,
    input logic [REG_W-1:0] new_v,
    input logic [1:0]       strb
  );
    lane_merge = {strb[1] ? new_v[15:8] : old_v[15:8],
                  strb[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------

  logic [REG_W-1:0]  ctrl_r;
  logic [REG_W-1:0]  ctrl_nxt;
  logic              xvar_r;
  logic              xvar_nxt;
  logic              restart_r;
  logic              restart_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic              err_r;
  logic              err_nxt;

  // synchronised transceiver status
  logic [N_STS_IN-1:0] sts_async;
  logic [N_STS_IN-1:0] sts_sync;
  logic                pol_s;
  logic                rxfc_s;
  logic                txfc_s;
  logic                fef_s;
  logic                amdix_s;
  logic                and_s;
  logic                link_s;
  logic                ans_s;
  logic                anx_s;
  logic [N_ABIL-1:0]   lp_s;

  // resolved operating mode
  logic op_speed;
  logic op_duplex;
  logic mdix_sel;

  // decode
  logic              setup_ph;
  logic              access_ph;
  logic              hit_ctrl;
  logic              hit_stat;
  logic              hit_rsvd;
  logic              hit_any;
  logic              wr_ctrl;
  logic              wr_stat;
  logic [REG_W-1:0]  wdata16;
  logic [REG_W-1:0]  status_word;
  logic [REG_W-1:0]  rd_word;
  logic [ADDR_W-1:0] rsvd_lo;
  logic [ADDR_W-1:0] rsvd_hi;
  logic              fef_seen;

  // ------------------------------------------------------------------
  // status inputs cross into clk_i through the three-stage filter
  // ------------------------------------------------------------------

  assign sts_async = {polarity_rev_i, rx_flow_active_i, tx_flow_active_i,
                      far_end_fault_i, auto_mdix_i, an_done_i, link_good_i,
                      an_speed_i, an_duplex_i, partner_abil_i};

  ppcs_sync3 #(
    .W (N_STS_IN)
  ) u_sts_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (sts_async),
    .level_o  (sts_sync)
  );

  assign {pol_s, rxfc_s, txfc_s, fef_s, amdix_s, and_s, link_s,
          ans_s, anx_s, lp_s} = sts_sync;

  // ------------------------------------------------------------------
  // speed, duplex and wiring selection
  // ------------------------------------------------------------------

  ppcs_mode_resolve u_mode (
    .an_en_i        (ctrl_r[CTL_AN_EN]),
    .an_done_i      (and_s),
    .an_speed_i     (ans_s),
    .an_duplex_i    (anx_s),
    .force_speed_i  (ctrl_r[CTL_SPEED]),
    .force_duplex_i (ctrl_r[CTL_DUPLEX]),
    .amdix_dis_i    (ctrl_r[CTL_AMDIX_DIS]),
    .force_mdix_i   (ctrl_r[CTL_FORCE_MDIX]),
    .auto_mdix_i    (amdix_s),
    .speed_o        (op_speed),
    .duplex_o       (op_duplex),
    .mdix_o         (mdix_sel)
  );

  // ------------------------------------------------------------------
  // apb decode; zero wait states, so pready is tied high
  // ------------------------------------------------------------------

  assign setup_ph  = psel_i & ~penable_i;
  assign access_ph = psel_i & penable_i;
  assign rsvd_lo   = idx_addr(IDX_RSVD_FIRST);
  assign rsvd_hi   = idx_addr(IDX_RSVD_LAST);
  assign hit_ctrl  = paddr_i == idx_addr(IDX_CTRL);
  assign hit_stat  = paddr_i == idx_addr(IDX_STAT);
  // reserved range: every aligned word between the two ends
  assign hit_rsvd  = (paddr_i >= rsvd_lo) & (paddr_i <= rsvd_hi) &
                     (paddr_i[1:0] == 2'b00);
  assign hit_any   = hit_ctrl | hit_stat | hit_rsvd;
  assign wdata16   = pwdata_i[REG_W-1:0];
  assign wr_ctrl   = access_ph & pwrite_i & hit_ctrl;
  assign wr_stat   = access_ph & pwrite_i & hit_stat;

  // ------------------------------------------------------------------
  // status word; fault reads zero while detection is disabled
  // ------------------------------------------------------------------

  assign fef_seen = fef_s & ~ctrl_r[CTL_FEF_DIS]; // [R4] [R15]

  always_comb begin
    status_word                         = '0; // [R12]
    status_word[STS_XVARIANT]           = xvar_r; // [R11]
    status_word[STS_POL_REV]            = pol_s; // [R12]
    status_word[STS_RX_FC]              = rxfc_s; // [R13]
    status_word[STS_TX_FC]              = txfc_s; // [R13]
    status_word[STS_SPEED]              = op_speed; // [R14]
    status_word[STS_DUPLEX]             = op_duplex; // [R14]
    status_word[STS_FEF]                = fef_seen; // [R15]
    status_word[STS_MDIX]               = mdix_sel; // [R18]
    status_word[STS_AN_DONE]            = and_s; // [R18]
    status_word[STS_LINK]               = link_s; // [R18]
    status_word[STS_LP_MSB:0]           = lp_s; // [R16]
  end

  // read mux; reserved words and misses answer zero
  assign rd_word = hit_ctrl ? ctrl_r :
                   hit_stat ? status_word :
                   RSVD_VALUE; // [R17]

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------

  // control word follows byte lanes; writes elsewhere are dropped
  assign ctrl_nxt = wr_ctrl ? lane_merge(ctrl_r, wdata16, pstrb_i[1:0])
                            : ctrl_r;

  // only the variant bit of the status word is writable
  assign xvar_nxt = (wr_stat & pstrb_i[1]) ? wdata16[STS_XVARIANT]
                                           : xvar_r; // [R11]

  // one-cycle restart pulse for each write of one to the bit
  assign restart_nxt = wr_ctrl & pstrb_i[1] &
                       wdata16[CTL_AN_RESTART]; // [R3]

  // read data is captured at setup so it stands through access
  assign rdata_nxt = setup_ph ? {{(DATA_W-REG_W){1'b0}}, rd_word}
                              : rdata_r;

  // unmapped address answers with an error at access
  assign err_nxt = setup_ph ? ~hit_any : err_r;

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------

  // control word and writable status bit
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_r <= CTRL_RST; // [R7] [R10]
      xvar_r <= XVARIANT_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      xvar_r <= xvar_nxt;
    end
  end

  // bus answer and restart strobe
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r   <= '0;
      err_r     <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      rdata_r   <= rdata_nxt;
      err_r     <= err_nxt;
      restart_r <= restart_nxt;
    end
  end

  assign prdata_o  = rdata_r;
  assign pready_o  = 1'b1;
  assign pslverr_o = access_ph & err_r;

  // ------------------------------------------------------------------
  // transceiver controls
  // ------------------------------------------------------------------

  // indicators forced high (dark) rather than tri-stated
  assign indicator_out_3_o = indicator_src_i[3] | ctrl_r[CTL_LED_OFF]; // [R1]
  assign indicator_out_2_o = indicator_src_i[2] | ctrl_r[CTL_LED_OFF]; // [R1]
  assign indicator_out_1_o = indicator_src_i[1] | ctrl_r[CTL_LED_OFF]; // [R1]
  assign indicator_out_0_o = indicator_src_i[0] | ctrl_r[CTL_LED_OFF]; // [R1]

  assign tx_disable_o  = ctrl_r[CTL_TX_DIS]; // [R2]
  // restart also stored in the word so software can read it back
  assign an_restart_o  = restart_r; // [R3]
  assign fef_enable_o  = ~ctrl_r[CTL_FEF_DIS]; // [R4]
  assign power_down_o  = ctrl_r[CTL_PWR_DOWN]; // [R19]
  assign mdix_select_o = mdix_sel; // [R5]
  assign loopback_o    = ctrl_r[CTL_LOOPBACK]; // [R6]
  assign an_enable_o   = ctrl_r[CTL_AN_EN]; // [R7]
  assign op_speed_o    = op_speed; // [R8] [R14]
  assign op_duplex_o   = op_duplex; // [R9] [R14]
  assign advert_o      = ctrl_r[CTL_ADV_MSB:0]; // [R10]
  assign crossover_variant_select_o = xvar_r; // [R11]

  // ------------------------------------------------------------------
  // aliased phy views share the same flops, so they never disagree
  // ------------------------------------------------------------------

  always_comb begin
    phy_basic_control_alias_o                 = '0;
    phy_basic_control_alias_o[ALS_LED_OFF]    = ctrl_r[CTL_LED_OFF];
    phy_basic_control_alias_o[ALS_TX_DIS]     = ctrl_r[CTL_TX_DIS];
    phy_basic_control_alias_o[ALS_FEF_DIS]    = ctrl_r[CTL_FEF_DIS];
    phy_basic_control_alias_o[ALS_AMDIX_DIS]  = ctrl_r[CTL_AMDIX_DIS];
    phy_basic_control_alias_o[ALS_FORCE_MDIX] = ctrl_r[CTL_FORCE_MDIX];
    phy_basic_control_alias_o[ALS_XVARIANT]   = xvar_r;
    phy_basic_control_alias_o[ALS_DUPLEX]     = ctrl_r[CTL_DUPLEX];
    phy_basic_control_alias_o[ALS_AN_RESTART] = ctrl_r[CTL_AN_RESTART];
    phy_basic_control_alias_o[ALS_PWR_DOWN]   = ctrl_r[CTL_PWR_DOWN];
    phy_basic_control_alias_o[ALS_AN_EN]      = ctrl_r[CTL_AN_EN];
    phy_basic_control_alias_o[ALS_SPEED]      = ctrl_r[CTL_SPEED];
    phy_basic_control_alias_o[ALS_LOOPBACK]   = ctrl_r[CTL_LOOPBACK]; // [R19]
  end

  // advertisement alias carries the same five ability bits
  assign phy_advert_alias_o = {{(REG_W-N_ABIL){1'b0}},
                               ctrl_r[CTL_ADV_MSB:0]}; // [R19]

  // basic status alias: the whole status word, variant bit 15 included
  assign phy_basic_status_alias_o = status_word; // [R19]

endmodule

// ---- logic/ppcs_sync3.sv ----
`timescale 1ns/1ps
// three-stage synchroniser with agreement filter
module ppcs_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] level_nxt;

  // refused at elaboration: the filter needs at least one bit
  if (W < 1) begin : g_bad_width
    $error("ppcs_sync3: width must be at least one");
  end

  // a bit changes only once stages two and three agree
  assign level_nxt = (s2_r & s3_r) | (level_o & (s2_r | s3_r));

  // first stage is read by the second stage alone
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_r    <= '0;
      s2_r    <= '0;
      s3_r    <= '0;
      level_o <= '0;
    end else begin
      s1_r    <= async_i;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_o <= level_nxt;
    end
  end

endmodule

// ---- testbench/ppcs_regs_assertions.sv ----
`timescale 1ns/1ps
// watches the register block from its pins only
module ppcs_regs_checker
  import ppcs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [13:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pslverr_o,
  input  wire logic [3:0]  indicator_src_i,
  input  wire logic        indicator_out_0_o,
  input  wire logic        indicator_out_3_o,
  input  wire logic        tx_disable_o,
  input  wire logic        an_restart_o,
  input  wire logic        fef_enable_o,
  input  wire logic        mdix_select_o,
  input  wire logic        loopback_o,
  input  wire logic        an_enable_o,
  input  wire logic        op_speed_o,
  input  wire logic        op_duplex_o,
  input  wire logic [4:0]  advert_o,
  input  wire logic [15:0] phy_basic_control_alias_o,
  input  wire logic [15:0] phy_advert_alias_o,
  input  wire logic [15:0] phy_basic_status_alias_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // access decode; the alias stands in for the hidden control word
  logic [15:0] cw;
  logic        ctl_wr;
  logic        rsv_rd;
  logic [4:0]  wd_r;
  assign cw = phy_basic_control_alias_o;
  assign ctl_wr = psel_i & penable_i & pwrite_i & (paddr_i == 14'h1448);
  assign rsv_rd = psel_i & penable_i & !pwrite_i
                  & (paddr_i inside {14'h1458, 14'h1460, 14'h1468});
  // write data kept one cycle so the register update can be compared
  always_ff @(posedge clk_i) begin
    wd_r <= pwdata_i[4:0];
  end
  a_led_off_high: assert property (
    indicator_out_0_o == (indicator_src_i[0] | cw[ALS_LED_OFF]) &&
    indicator_out_3_o == (indicator_src_i[3] | cw[ALS_LED_OFF]))
    else $error("indicator level wrong");
  a_tx_disable: assert property (tx_disable_o == cw[ALS_TX_DIS])
    else $error("transmit disable wrong");
  a_restart_pulse: assert property (
    ctl_wr && pstrb_i[1] && pwdata_i[13] |=> an_restart_o ##1 !an_restart_o)
    else $error("restart pulse wrong");
  a_fef_inverse: assert property (fef_enable_o != cw[ALS_FEF_DIS])
    else $error("far end fault enable wrong");
  a_mdix_forced: assert property (
    cw[ALS_AMDIX_DIS] |-> mdix_select_o == cw[ALS_FORCE_MDIX])
    else $error("forced crossover wrong");
  a_loop_follow: assert property (loopback_o == cw[ALS_LOOPBACK])
    else $error("loopback wrong");
  a_an_enable: assert property (an_enable_o == cw[ALS_AN_EN])
    else $error("negotiation enable wrong");
  a_forced_mode: assert property (!an_enable_o |->
    op_speed_o == cw[ALS_SPEED] && op_duplex_o == cw[ALS_DUPLEX])
    else $error("forced speed or duplex wrong");
  a_advert_write: assert property (ctl_wr && pstrb_i[0] |=>
    advert_o == wd_r && phy_advert_alias_o[4:0] == wd_r)
    else $error("advertised abilities wrong");
  a_status_rsvd: assert property (!phy_basic_status_alias_o[14])
    else $error("status bit 14 not zero");
  a_rsvd_zero: assert property (
    rsv_rd |-> prdata_o == 32'h0000_0000 && !pslverr_o)
    else $error("reserved word not zero");
endmodule

bind ppcs_regs ppcs_regs_checker i_ppcs_regs_checker (
  .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
  .pslverr_o(pslverr_o), .indicator_src_i(indicator_src_i),
  .indicator_out_0_o(indicator_out_0_o),
  .indicator_out_3_o(indicator_out_3_o), .tx_disable_o(tx_disable_o),
  .an_restart_o(an_restart_o), .fef_enable_o(fef_enable_o),
  .mdix_select_o(mdix_select_o), .loopback_o(loopback_o),
  .an_enable_o(an_enable_o), .op_speed_o(op_speed_o),
  .op_duplex_o(op_duplex_o), .advert_o(advert_o),
  .phy_basic_control_alias_o(phy_basic_control_alias_o),
  .phy_advert_alias_o(phy_advert_alias_o),
  .phy_basic_status_alias_o(phy_basic_status_alias_o));

// ---- testbench/ppcs_regs_bench.sv ----
`timescale 1ns/1ps
module ppcs_regs_bench;
  import ppcs_pkg::*;
  logic        clk_i, resetn_i, psel_i, penable_i, pwrite_i, err;
  logic [13:0] paddr_i, cfg, sts;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [3:0]  pstrb_i, indicator_src_i, ind;
  logic        pready_o, pslverr_o, an_restart_o, xvar;
  logic        tx_dis, fef_en, pwr_dn, mdix, loop, an_en, spd, dup;
  logic [4:0]  advert;
  logic [15:0] pbc, pba, pbs;
  logic [12:0] outs;
  logic [13:0] rsv [3] = '{14'h1458, 14'h1460, 14'h1468};
  int          bad_count, check_count;
  assign outs = {tx_dis, fef_en, pwr_dn, mdix, loop, an_en, spd, dup, advert};

  ppcs_regs i_ppcs_regs (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .indicator_src_i(indicator_src_i), .indicator_out_3_o(ind[3]),
    .indicator_out_2_o(ind[2]), .indicator_out_1_o(ind[1]),
    .indicator_out_0_o(ind[0]), .polarity_rev_i(sts[13]),
    .rx_flow_active_i(sts[12]), .tx_flow_active_i(sts[11]),
    .an_speed_i(sts[10]), .an_duplex_i(sts[9]), .far_end_fault_i(sts[8]),
    .auto_mdix_i(sts[7]), .an_done_i(sts[6]), .link_good_i(sts[5]),
    .partner_abil_i(sts[4:0]), .tx_disable_o(tx_dis),
    .an_restart_o(an_restart_o), .fef_enable_o(fef_en),
    .power_down_o(pwr_dn), .mdix_select_o(mdix), .loopback_o(loop),
    .an_enable_o(an_en), .op_speed_o(spd), .op_duplex_o(dup),
    .advert_o(advert), .crossover_variant_select_o(xvar),
    .phy_basic_control_alias_o(pbc), .phy_advert_alias_o(pba),
    .phy_basic_status_alias_o(pbs));

  ppcs_xcvr_model i_ppcs_xcvr_model (
    .cfg_i(cfg), .power_down_i(pwr_dn), .sts_o(sts));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic close_out();
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask

  // one transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [13:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // no wait-state count assumed; loops until pready is seen high at an edge
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rdc(input string n, input logic [13:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, e, rd);
    chk("pslverr", 32'h0, {31'h0, err});
  endtask

  // hang guard, well beyond the length of the sequence
  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    close_out();
  end

  initial begin
    resetn_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 14'h0000;
    pwdata_i = 32'h0000_0000;
    pstrb_i = 4'hf;
    indicator_src_i = 4'h5;
    cfg = 14'h0000;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    rdc("ctrl", 14'h1448, 32'h0000_009f);
    rdc("status", 14'h1450, 32'h0000_0000);
    chk("outs", 32'h0000_089f, 32'(outs));
    chk("ind", 32'h5, 32'(ind));
    // every control bit set at once
    apb(1'b1, 14'h1448, 32'h0000_ffff);
    @(negedge clk_i);
    chk("restart", 32'h1, 32'(an_restart_o));
    @(negedge clk_i);
    chk("restart", 32'h0, 32'(an_restart_o));
    chk("ind", 32'hf, 32'(ind));
    chk("outs", 32'h0000_17bf, 32'(outs));
    chk("alias", 32'h0000_7b1f, 32'(pbc));
    rdc("ctrl", 14'h1448, 32'h0000_ffff);
    // forced speed and duplex, all four combinations
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 14'h1448, 32'(i) << 5);
      @(negedge clk_i);
      chk("outs", 32'h800 | (32'(i) << 5), 32'(outs));
    end
    chk("ind", 32'h5, 32'(ind));
    apb(1'b1, 14'h1448, 32'h0000_009f);
    cfg <= 14'h3ff5;
    repeat (10) @(posedge clk_i);
    rdc("status", 14'h1450, 32'h0000_3ff5);
    apb(1'b1, 14'h1450, 32'h0000_ffff);
    rdc("status", 14'h1450, 32'h0000_bff5);
    chk("variant", 32'h1, 32'(xvar));
    // fault masked, negotiation not done so duplex from control
    apb(1'b1, 14'h1448, 32'h0000_109f);
    cfg <= 14'h052a;
    repeat (10) @(posedge clk_i);
    rdc("status", 14'h1450, 32'h0000_842a);
    chk("status alias", 32'h0000_842a, 32'(pbs));
    // reserved words ignore writes; an unmapped word errors
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, rsv[i], 32'h0000_ffff);
      rdc("reserved", rsv[i], 32'h0000_0000);
    end
    apb(1'b0, 14'h1470, 32'h0000_0000);
    chk("unmapped err", 32'h1, 32'(err));
    apb(1'b1, 14'h1470, 32'h0000_ffff);
    rdc("ctrl", 14'h1448, 32'h0000_109f);
    // low lane only: upper byte, restart bit included, is kept
    pstrb_i <= 4'h1;
    apb(1'b1, 14'h1448, 32'h0000_ff60);
    pstrb_i <= 4'hf;
    rdc("ctrl", 14'h1448, 32'h0000_1060);
    chk("outs", 32'h0000_0060, 32'(outs));
    chk("restart", 32'h0, 32'(an_restart_o));
    close_out();
  end
endmodule

// ---- testbench/ppcs_xcvr_model.sv ----
`timescale 1ns/1ps
// transceiver stand-in; bits line up with status bits 13:0
module ppcs_xcvr_model (
  input  wire logic [13:0] cfg_i,
  input  wire logic        power_down_i,
  output logic      [13:0] sts_o
);
  logic [13:0] lvl;
  // a powered-down phy loses link and negotiation result
  assign lvl = power_down_i ? (cfg_i & 14'h3f9f) : cfg_i;
  // levels move off the switch clock, so the sync path is exercised
  initial sts_o = 14'h0000;
  always @(lvl) begin
    sts_o <= #13 lvl;
  end
endmodule
